// file: src/uafet_test_override.sv
`timescale 1ns/100ps
`default_nettype none
module uafet_test_override
   import uafet_pkg::*;
(
   input  wire logic        clock,
   input  wire logic        rst,
   input  wire logic [11:0] avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   input  wire logic        fullspeed_diff_receiver_in,
   input  wire logic        highspeed_mode,
   input  wire logic        image_present,
   input  wire logic [2:0]  image_current_trim,
   input  wire logic        otp_programmed,
   input  wire logic [2:0]  otp_current_trim,
   input  wire logic        usb_reset,
   input  wire logic        lite_reset,
   input  wire logic        reset_protect,
   output logic             fullspeed_driver_enable_n,
   output logic             fullspeed_pos_line_drive,
   output logic             fullspeed_neg_line_drive,
   output logic      [1:0]  frontend_tx_valid_bus,
   output logic      [1:0]  highspeed_tx_bits,
   output logic             highspeed_serial_bit,
   output logic             highspeed_serial_valid,
   output logic             highspeed_current_source_on,
   output logic      [2:0]  output_current_trim,
   output logic             pos_line_pullup_on,
   output logic             neg_line_pullup_on,
   output logic             pos_line_pulldown_on,
   output logic             neg_line_pulldown_on,
   output logic             highspeed_driver_active
);

   // address decode, used by both the read and the write path
   function automatic logic uafet_hit(input logic [11:0] addr);
      uafet_hit = (addr[11:2] == UAFET_OFS_TEST[11:2]);
   endfunction

   // pack all fields into the software view; unlisted bits stay zero
   function automatic logic [31:0] uafet_pack
   (
      input logic       fs_oe_n,
      input logic       fs_vpos,
      input logic       fs_vneg,
      input logic       fs_rx,
      input logic [1:0] txv,
      input logic [1:0] txd,
      input logic       cs_en,
      input logic [2:0] trim,
      input logic [3:0] term,
      input logic       hs_act
   );
      logic [31:0] w;
      w = 32'h0000_0000;
      w[UAFET_B_FS_OE_N]                  = fs_oe_n;
      w[UAFET_B_FS_VPOS]                  = fs_vpos;
      w[UAFET_B_FS_VNEG]                  = fs_vneg;
      w[UAFET_B_FS_RX]                    = fs_rx;
      w[UAFET_B_TXV_LO+1:UAFET_B_TXV_LO]  = txv;
      w[UAFET_B_TXD_LO+1:UAFET_B_TXD_LO]  = txd;
      w[UAFET_B_CS_EN]                    = cs_en;
      w[UAFET_B_TRIM_LO+2:UAFET_B_TRIM_LO] = trim;
      w[UAFET_B_RPU_POS:UAFET_B_RPD_NEG]  = term;
      w[UAFET_B_HS_ACT]                   = hs_act;
      uafet_pack = w;
   endfunction

   uafet_bus_state_t state_q;
   uafet_bus_state_t state_d;
   logic             wait_q;
   logic [31:0]      rdata_q;
   logic             req;
   logic             commit;
   logic             wr_hit;
   logic             wr_lane0;
   logic             wr_lane1;
   logic             wr_lane2;

   logic             fs_oe_n_q;
   logic             fs_vpos_q;
   logic             fs_vneg_q;
   logic             fs_rx_q;
   logic [1:0]       txv_q;
   logic [1:0]       txd_q;
   logic             cs_en_q;
   logic [3:0]       term_q;
   logic             hs_act_q;
   logic [2:0]       trim;
   logic [1:0]       txv_wr;
   logic             ser_bit;
   logic             ser_valid;

   assign req = avs_read | avs_write;

   // a request is taken only in the answer state, where waitrequest is low
   assign commit   = (state_q == UAFET_S_ANS) & req;
   assign wr_hit   = commit & avs_write & uafet_hit(avs_address);
   assign wr_lane0 = wr_hit & avs_byteenable[0];
   assign wr_lane1 = wr_hit & avs_byteenable[1];
   assign wr_lane2 = wr_hit & avs_byteenable[2];

   // two states: see the request, then answer it one cycle later
   always_comb
   begin
      state_d = state_q;
      unique case (state_q)
         UAFET_S_IDLE:
         begin
            if (req)
               state_d = UAFET_S_ANS;
         end
         UAFET_S_ANS:
         begin
            state_d = UAFET_S_IDLE;
         end
         default:
         begin
            state_d = UAFET_S_IDLE;
         end
      endcase
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         state_q <= UAFET_S_IDLE;
      else
         state_q <= state_d;
   end

   // waitrequest is a flop: high at rest, low for exactly the answer cycle
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         wait_q <= 1'b1;
      else
         wait_q <= (state_d != UAFET_S_ANS);
   end

   // read data snapshotted as the answer opens; unmapped reads give zero
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         rdata_q <= UAFET_RD_UNMAPPED;
      else if (state_q == UAFET_S_IDLE && avs_read)
      begin
         if (uafet_hit(avs_address))
            rdata_q <= uafet_pack(fs_oe_n_q, fs_vpos_q, fs_vneg_q, fs_rx_q,
                                  txv_q, txd_q, cs_en_q, trim, term_q, hs_act_q);
         else
            rdata_q <= UAFET_RD_UNMAPPED;
      end
   end

   // full-speed driver override bits, byte lane 2
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         fs_oe_n_q <= UAFET_RST_BIT;
         fs_vpos_q <= UAFET_RST_BIT;
         fs_vneg_q <= UAFET_RST_BIT;
      end
      else if (wr_lane2)
      begin
         fs_oe_n_q <= avs_writedata[UAFET_B_FS_OE_N];
         fs_vpos_q <= avs_writedata[UAFET_B_FS_VPOS];
         fs_vneg_q <= avs_writedata[UAFET_B_FS_VNEG];
      end
   end

   // receiver input is synchronous; one flop keeps the readback clean
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         fs_rx_q <= UAFET_RST_BIT;
      else
         fs_rx_q <= fullspeed_diff_receiver_in;
   end

   // a write of the forbidden mask code is dropped, old mask stands
   assign txv_wr = avs_writedata[UAFET_B_TXV_LO+1:UAFET_B_TXV_LO];

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         txv_q <= UAFET_RST_PAIR;
      else if (wr_lane1 && txv_wr != UAFET_TXV_BAD)
         txv_q <= txv_wr;
   end

   // high-speed transmit bits
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         txd_q <= UAFET_RST_PAIR;
      else if (wr_lane1)
         txd_q <= avs_writedata[UAFET_B_TXD_LO+1:UAFET_B_TXD_LO];
   end

   // high-speed mode wins over a software clear in the same cycle
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         cs_en_q <= UAFET_RST_BIT;
      else if (highspeed_mode)
         cs_en_q <= 1'b1;
      else if (wr_lane1)
         cs_en_q <= avs_writedata[UAFET_B_CS_EN];
   end

   // pull-up and pull-down termination, byte lane 0
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         term_q <= {UAFET_RST_PAIR, UAFET_RST_PAIR};
      else if (wr_lane0)
         term_q <= avs_writedata[UAFET_B_RPU_POS:UAFET_B_RPD_NEG];
   end

   // driver active control, also byte lane 0
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         hs_act_q <= UAFET_RST_BIT;
      else if (wr_lane0)
         hs_act_q <= avs_writedata[UAFET_B_HS_ACT];
   end

   // trim has its own load and reload sources besides software
   uafet_trim_load u_trim
   (
      .clock              (clock),
      .rst                (rst),
      .image_present      (image_present),
      .image_current_trim (image_current_trim),
      .otp_programmed     (otp_programmed),
      .otp_current_trim   (otp_current_trim),
      .usb_reset          (usb_reset),
      .lite_reset         (lite_reset),
      .reset_protect      (reset_protect),
      .wr_en              (wr_lane1),
      .wr_data            (avs_writedata[UAFET_B_TRIM_LO+2:UAFET_B_TRIM_LO]),
      .trim               (trim)
   );

   // serial feed of the transmit bits as the mask allows
   uafet_hs_serial u_ser
   (
      .clock        (clock),
      .rst          (rst),
      .valid_mask   (txv_q),
      .tx_bits      (txd_q),
      .serial_bit   (ser_bit),
      .serial_valid (ser_valid)
   );

   // bus outputs
   assign avs_readdata    = rdata_q;
   assign avs_waitrequest = wait_q;

   // front-end controls, each straight off a flop: its field flop, or the serializer flops for the serial bit and valid
   assign fullspeed_driver_enable_n   = fs_oe_n_q;
   assign fullspeed_pos_line_drive    = fs_vpos_q;
   assign fullspeed_neg_line_drive    = fs_vneg_q;
   assign frontend_tx_valid_bus       = txv_q;
   assign highspeed_tx_bits           = txd_q;
   assign highspeed_serial_bit        = ser_bit;
   assign highspeed_serial_valid      = ser_valid;
   assign highspeed_current_source_on = cs_en_q;
   assign output_current_trim         = trim;
   assign pos_line_pullup_on          = term_q[3];
   assign neg_line_pullup_on          = term_q[2];
   assign pos_line_pulldown_on        = term_q[1];
   assign neg_line_pulldown_on        = term_q[0];
   assign highspeed_driver_active     = hs_act_q;

endmodule
`default_nettype wire

// file: pkg/uafet_pkg.sv
`default_nettype none
package uafet_pkg;

   // bus geometry and register placement
   localparam int unsigned UAFET_ADDR_W      = 12;
   localparam logic [11:0] UAFET_OFS_TEST    = 12'h0c4;

   // field positions inside the test override register
   localparam int unsigned UAFET_B_FS_OE_N   = 22;
   localparam int unsigned UAFET_B_FS_VPOS   = 21;
   localparam int unsigned UAFET_B_FS_VNEG   = 20;
   localparam int unsigned UAFET_B_FS_RX     = 19;
   localparam int unsigned UAFET_B_TXV_LO    = 14;
   localparam int unsigned UAFET_B_TXD_LO    = 12;
   localparam int unsigned UAFET_B_CS_EN     = 11;
   localparam int unsigned UAFET_B_TRIM_LO   = 8;
   localparam int unsigned UAFET_B_RPU_POS   = 7;
   localparam int unsigned UAFET_B_RPU_NEG   = 6;
   localparam int unsigned UAFET_B_RPD_POS   = 5;
   localparam int unsigned UAFET_B_RPD_NEG   = 4;
   localparam int unsigned UAFET_B_HS_ACT    = 1;

   // reset values
   localparam logic        UAFET_RST_BIT     = 1'b0;
   localparam logic [1:0]  UAFET_RST_PAIR    = 2'h0;
   localparam logic [2:0]  UAFET_RST_TRIM    = 3'h0;
   localparam logic [31:0] UAFET_RD_UNMAPPED = 32'h0000_0000;

   // mask codes: 2'h2 is the one software must never use, then lsb only and both
   localparam logic [1:0]  UAFET_TXV_BAD     = 2'h2;
   localparam logic [1:0]  UAFET_TXV_LSB     = 2'h1;
   localparam logic [1:0]  UAFET_TXV_BOTH    = 2'h3;

   // slave answer sequencing
   typedef enum logic [1:0]
   {
      UAFET_S_IDLE = 2'b01,
      UAFET_S_ANS  = 2'b10
   } uafet_bus_state_t;

endpackage
`default_nettype wire

// file: src/uafet_trim_load.sv
`timescale 1ns/100ps
`default_nettype none
module uafet_trim_load
   import uafet_pkg::*;
(
   input  wire logic       clock,
   input  wire logic       rst,
   input  wire logic       image_present,
   input  wire logic [2:0] image_current_trim,
   input  wire logic       otp_programmed,
   input  wire logic [2:0] otp_current_trim,
   input  wire logic       usb_reset,
   input  wire logic       lite_reset,
   input  wire logic       reset_protect,
   input  wire logic       wr_en,
   input  wire logic [2:0] wr_data,
   output logic      [2:0] trim
);

   logic       loaded_q;
   logic [2:0] last_image_q;
   logic [2:0] trim_q;

   // straps are caught on the first clock after release, not under reset
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         loaded_q <= 1'b0;
      else
         loaded_q <= 1'b1;
   end

   // remember the image value taken at load for later reloads
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         last_image_q <= UAFET_RST_TRIM;
      else if (!loaded_q)
         last_image_q <= image_present ? image_current_trim : UAFET_RST_TRIM;
   end

   // reload beats a software write landing in the same cycle
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         trim_q <= UAFET_RST_TRIM;
      else if (!loaded_q)
         trim_q <= image_present  ? image_current_trim :
                   otp_programmed ? otp_current_trim : UAFET_RST_TRIM;
      else if ((usb_reset || lite_reset) && !reset_protect)
         trim_q <= last_image_q;
      else if (wr_en)
         trim_q <= wr_data;
   end

   assign trim = trim_q;

endmodule
`default_nettype wire

// file: src/uafet_hs_serial.sv
`timescale 1ns/100ps
`default_nettype none
module uafet_hs_serial
   import uafet_pkg::*;
(
   input  wire logic       clock,
   input  wire logic       rst,
   input  wire logic [1:0] valid_mask,
   input  wire logic [1:0] tx_bits,
   output logic            serial_bit,
   output logic            serial_valid
);

   logic phase_q;
   logic bit_q;
   logic valid_q;

   // phase only advances when both bits are sent, so lsb always leads
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         phase_q <= 1'b0;
      else if (valid_mask == UAFET_TXV_BOTH)
         phase_q <= ~phase_q;
      else
         phase_q <= 1'b0;
   end

   // serial output, lsb first; a forbidden mask sends nothing
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         bit_q   <= UAFET_RST_BIT;
         valid_q <= UAFET_RST_BIT;
      end
      else
      begin
         unique case (valid_mask)
            UAFET_TXV_BOTH:
            begin
               bit_q   <= tx_bits[phase_q];
               valid_q <= 1'b1;
            end
            UAFET_TXV_LSB:
            begin
               bit_q   <= tx_bits[0];
               valid_q <= 1'b1;
            end
            default:
            begin
               bit_q   <= UAFET_RST_BIT;
               valid_q <= 1'b0;
            end
         endcase
      end
   end

   assign serial_bit   = bit_q;
   assign serial_valid = valid_q;

endmodule
`default_nettype wire

// file: test/uafet_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module uafet_chk
   import uafet_pkg::*;
(
   input wire logic        clock,
   input wire logic        rst,
   input wire logic [11:0] avs_address,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0]  avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest,
   input wire logic        highspeed_mode,
   input wire logic        image_present,
   input wire logic [2:0]  image_current_trim,
   input wire logic        usb_reset,
   input wire logic        lite_reset,
   input wire logic        reset_protect,
   input wire logic        fullspeed_driver_enable_n,
   input wire logic        fullspeed_pos_line_drive,
   input wire logic        fullspeed_neg_line_drive,
   input wire logic [1:0]  frontend_tx_valid_bus,
   input wire logic [1:0]  highspeed_tx_bits,
   input wire logic        highspeed_serial_bit,
   input wire logic        highspeed_serial_valid,
   input wire logic        highspeed_current_source_on,
   input wire logic [2:0]  output_current_trim,
   input wire logic        pos_line_pullup_on,
   input wire logic        neg_line_pullup_on,
   input wire logic        pos_line_pulldown_on,
   input wire logic        neg_line_pulldown_on,
   input wire logic        highspeed_driver_active
);
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   logic up_q;
   logic [2:0] img_q;
   logic hit;
   logic wr;
   logic rd;
   logic rld;
   // accepted transfers and reload requests
   assign hit = avs_address[11:2] == UAFET_OFS_TEST[11:2];
   assign wr  = avs_write && !avs_waitrequest && hit;
   assign rd  = avs_read && !avs_waitrequest;
   assign rld = (usb_reset || lite_reset) && !reset_protect;
   // masks the trim load edge, which moves trim legally; keeps the image value seen there
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         up_q  <= 1'b0;
         img_q <= 3'h0;
      end
      else
      begin
         up_q <= 1'b1;
         if (!up_q)
            img_q <= image_present ? image_current_trim : 3'h0;
      end
   end
   chk_wait_one: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low too long");
   chk_answer_bound: assert property ((avs_read || avs_write) |-> ##[0:2] !avs_waitrequest)
      else $error("bus answer late");
   chk_fs_write: assert property (wr && avs_byteenable[2] |=>
      {fullspeed_driver_enable_n, fullspeed_pos_line_drive, fullspeed_neg_line_drive} == $past(avs_writedata[22:20]))
      else $error("fs fields wrong");
   chk_mask_bad: assert property (wr && avs_byteenable[1] && avs_writedata[15:14] == UAFET_TXV_BAD |=>
      $stable(frontend_tx_valid_bus)) else $error("bad mask taken");
   chk_tx_write: assert property (wr && avs_byteenable[1] && avs_writedata[15:14] != UAFET_TXV_BAD |=>
      {frontend_tx_valid_bus, highspeed_tx_bits} == $past(avs_writedata[15:12])) else $error("tx fields wrong");
   chk_lsb_serial: assert property (frontend_tx_valid_bus == UAFET_TXV_LSB |=>
      highspeed_serial_valid && highspeed_serial_bit == $past(highspeed_tx_bits[0])) else $error("lsb serial");
   chk_idle_serial: assert property (frontend_tx_valid_bus == 2'h0 |=> !highspeed_serial_valid)
      else $error("serial valid idle");
   chk_cs_forced: assert property (highspeed_mode |=> highspeed_current_source_on)
      else $error("current source off");
   chk_trim_write: assert property (up_q && wr && avs_byteenable[1] && !rld |=>
      output_current_trim == $past(avs_writedata[10:8])) else $error("trim write");
   chk_trim_keep: assert property (up_q && reset_protect && !(wr && avs_byteenable[1]) |=>
      $stable(output_current_trim)) else $error("protected trim moved");
   chk_trim_reload: assert property (up_q && rld |=>
      output_current_trim == $past(img_q)) else $error("trim reload");
   chk_term_write: assert property (wr && avs_byteenable[0] |=>
      {pos_line_pullup_on, neg_line_pullup_on, pos_line_pulldown_on, neg_line_pulldown_on,
       highspeed_driver_active} == $past({avs_writedata[7:4], avs_writedata[1]})) else $error("lane0 fields");
   chk_rsvd_zero: assert property (rd |-> (avs_readdata & 32'hff87_000d) == 32'h0)
      else $error("reserved bits set");
   chk_unmapped_rd: assert property (rd && !hit |-> avs_readdata == UAFET_RD_UNMAPPED)
      else $error("unmapped read");
   cov_write: cover property (wr);
   cov_unmapped: cover property (rd && !hit);
   cov_reload: cover property (up_q && rld);
endmodule
`default_nettype wire

// file: test/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench
   import uafet_pkg::*;
;
   logic        clock = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
   logic [11:0] avs_address = 12'h0;
   logic [31:0] avs_writedata = 32'h0, avs_readdata, ow, rd_q;
   logic [3:0]  avs_byteenable = 4'h0;
   logic        fullspeed_diff_receiver_in = 1'b0, highspeed_mode = 1'b0, image_present = 1'b0;
   logic        otp_programmed = 1'b0, usb_reset = 1'b0, lite_reset = 1'b0, reset_protect = 1'b0;
   logic [2:0]  image_current_trim = 3'h0, otp_current_trim = 3'h0, output_current_trim;
   logic        avs_waitrequest, fullspeed_driver_enable_n, fullspeed_pos_line_drive, fullspeed_neg_line_drive;
   logic [1:0]  frontend_tx_valid_bus, highspeed_tx_bits;
   logic        highspeed_serial_bit, highspeed_serial_valid, highspeed_current_source_on, highspeed_driver_active;
   logic        pos_line_pullup_on, neg_line_pullup_on, pos_line_pulldown_on, neg_line_pulldown_on;
   int          n_mismatch = 0, checked = 0;
   // 40 MHz
   always #12.5 clock = ~clock;
   uafet_test_override dut (.*);
   // outputs folded back onto register bit positions, receiver bit left 0
   assign ow = {9'h0, fullspeed_driver_enable_n, fullspeed_pos_line_drive, fullspeed_neg_line_drive, 4'h0,
                frontend_tx_valid_bus, highspeed_tx_bits, highspeed_current_source_on, output_current_trim,
                pos_line_pullup_on, neg_line_pullup_on, pos_line_pulldown_on, neg_line_pulldown_on, 2'h0,
                highspeed_driver_active, 1'b0};
   task end_sim;
      if (n_mismatch == 0 && checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task cmp(input logic [31:0] g, input logic [31:0] e);
      checked++;
      if (g !== e)
      begin
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
         n_mismatch++;
      end
   endtask
   // one bus transfer, held until waitrequest is seen low
   task xfer(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] be);
      int n;
      n = 0;
      avs_address <= a;
      avs_writedata <= d;
      avs_byteenable <= be;
      avs_write <= w;
      avs_read <= !w;
      do
      begin
         @(posedge clock);
         n++;
      end
      while (avs_waitrequest !== 1'b0 && n < 50);
      rd_q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      if (avs_waitrequest !== 1'b0)
      begin
         n_mismatch++;
         end_sim;
      end
      @(posedge clock);
   endtask
   // readback and pins must agree with the expected word
   task chk_reg(input logic [31:0] e);
      xfer(1'b0, UAFET_OFS_TEST, 32'h0, 4'hf);
      cmp(rd_q, e);
      cmp(ow, e & 32'hfff7_ffff);
   endtask
   task do_reset(input logic ip, input logic [2:0] iv, input logic op, input logic [2:0] ov);
      image_present <= ip;
      image_current_trim <= iv;
      otp_programmed <= op;
      otp_current_trim <= ov;
      rst <= 1'b1;
      repeat (20) @(posedge clock);
      rst <= 1'b0;
      repeat (2) @(posedge clock);
   endtask
   task pulse(input logic u);
      if (u)
         usb_reset <= 1'b1;
      else
         lite_reset <= 1'b1;
      @(posedge clock);
      usb_reset <= 1'b0;
      lite_reset <= 1'b0;
      @(posedge clock);
   endtask
   task t_fields;
      xfer(1'b1, UAFET_OFS_TEST, 32'hffff_ffff, 4'hf);
      chk_reg(32'h0070_fff2);
      xfer(1'b1, UAFET_OFS_TEST, 32'h0, 4'h1);
      chk_reg(32'h0070_ff00);
      xfer(1'b1, UAFET_OFS_TEST, 32'h0030_0000, 4'h4);
      chk_reg(32'h0030_ff00);
      xfer(1'b1, UAFET_OFS_TEST, 32'h0000_8000, 4'h2);
      chk_reg(32'h0030_c000);
   endtask
   // serial stream for one mask and data setting
   task t_serial(input logic [31:0] d, input logic v, input logic b, input logic alt);
      logic p;
      xfer(1'b1, UAFET_OFS_TEST, d, 4'h2);
      // one more edge so the reference bit already comes from the new data
      @(posedge clock);
      p = highspeed_serial_bit;
      repeat (4)
      begin
         @(posedge clock);
         cmp({highspeed_serial_valid, highspeed_serial_bit & v}, {v, alt ? !p : b & v});
         p = highspeed_serial_bit;
      end
   endtask
   task t_rx_cs;
      fullspeed_diff_receiver_in <= 1'b1;
      xfer(1'b1, UAFET_OFS_TEST, 32'h0030_0000, 4'h4);
      chk_reg(32'h0038_0000);
      fullspeed_diff_receiver_in <= 1'b0;
      highspeed_mode <= 1'b1;
      xfer(1'b1, UAFET_OFS_TEST, 32'h0, 4'h2);
      chk_reg(32'h0030_0800);
      highspeed_mode <= 1'b0;
      xfer(1'b1, UAFET_OFS_TEST, 32'h0, 4'h2);
      chk_reg(32'h0030_0000);
   endtask
   task t_trim;
      xfer(1'b1, UAFET_OFS_TEST, 32'h0000_0300, 4'h2);
      reset_protect <= 1'b1;
      pulse(1'b1);
      chk_reg(32'h0030_0300);
      reset_protect <= 1'b0;
      pulse(1'b1);
      chk_reg(32'h0030_0500);
      xfer(1'b1, UAFET_OFS_TEST, 32'h0000_0600, 4'h2);
      pulse(1'b0);
      chk_reg(32'h0030_0500);
      do_reset(1'b0, 3'h0, 1'b1, 3'h2);
      chk_reg(32'h0000_0200);
      pulse(1'b1);
      chk_reg(32'h0);
      do_reset(1'b0, 3'h0, 1'b0, 3'h2);
      chk_reg(32'h0);
   endtask
   task t_unmapped;
      xfer(1'b1, 12'h0c8, 32'hffff_ffff, 4'hf);
      xfer(1'b0, 12'h0c8, 32'h0, 4'hf);
      cmp(rd_q, 32'h0);
      chk_reg(32'h0);
   endtask
   initial
   begin
      do_reset(1'b1, 3'h5, 1'b1, 3'h2);
      chk_reg(32'h0000_0500);
      t_fields;
      t_serial(32'h0000_e000, 1'b1, 1'b0, 1'b1);
      t_serial(32'h0000_5000, 1'b1, 1'b1, 1'b0);
      t_serial(32'h0000_0000, 1'b0, 1'b0, 1'b0);
      t_rx_cs;
      t_trim;
      t_unmapped;
      end_sim;
   end
endmodule
bind uafet_test_override uafet_chk chk (.*);
`default_nettype wire
